// file: common/rdy_cfg.svh
// constants for the external bus ready and wait-state controller
// assumes inclusion by the package and by the design files only
`ifndef RDY_CFG_SVH
`define RDY_CFG_SVH
`define RDY_REG_CTRL 4'h0
`define RDY_REG_PHASE 4'h1
`define RDY_REG_STAT 4'h2
`define RDY_REG_COUNT 4'h3
`define RDY_CTRL_POL_BIT 0
`define RDY_CTRL_ASYNC_BIT 1
`define RDY_PH_LEN_W 5
`define RDY_PH_E_LSB 0
`define RDY_PH_E_MSB 4
`define RDY_PH_C_LSB 8
`define RDY_PH_C_MSB 9
`define RDY_PH_RST 16'h0000
`define RDY_CTRL_RST 2'h0
`define RDY_CNT_W 16
`define RDY_CLKDIV_HALF 2'h1
`define RDY_ASYNC_EXTRA 5'h01
`define RDY_ONE_5 5'h01
`define RDY_ONE_16 16'h0001
`endif

// file: common/rdy_pkg.sv
// types for the external bus ready and wait-state controller
// assumes rdy_cfg.svh sits on the include path
`include "rdy_cfg.svh"
package rdy_pkg;
  typedef enum logic [3:0] {
    RDY_IDLE = 4'h1,
    RDY_CMD = 4'h2,
    RDY_ACC = 4'h4,
    RDY_WAIT = 4'h8
  } rdy_state_e;
  typedef struct packed {
    logic start;
    logic is_write;
  } rdy_req_s;
  typedef struct packed {
    logic cmd_n;
    logic wr_n;
    logic done;
    logic busy;
  } rdy_bus_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rdy_reg_s;
endpackage

// file: core/rdy_sync.sv
// two-stage synchroniser for the external ready pin
// assumes the input may change at any time relative to core_clk
`timescale 1ns/1ns
`default_nettype none
module rdy_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } rdy_sync_s;
  rdy_sync_s st_r;
  rdy_sync_s st_nxt;
  // first stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.s2;
endmodule
`default_nettype wire

// file: core/rdy_ctrl.sv
// ready handshake and wait-state control of one external bus cycle
// assumes a bus controller that pulses start and holds ready pin wiring
//
// Functional notes
// - ready polarity is chosen by a control bit, high or low active
// - synchronous mode samples the pin directly, no extra stage
// - asynchronous mode adds a synchroniser and, for access phase lengths 1 to 30, at least one wait state
// - first sample point follows the programmed phase lengths
// - inactive sample inserts one ready wait state, then sample again
// - active sample terminates the running bus cycle
// - asynchronous sample point is later than the synchronous one for access phase lengths 1 to 30
// - ready ignored until access phase mandatory waits are over
`timescale 1ns/1ns
`default_nettype none
`include "rdy_cfg.svh"
module rdy_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire rdy_pkg::rdy_reg_s reg_in,
  output logic [15:0] reg_rdata,
  // cycle request from the bus controller
  input wire rdy_pkg::rdy_req_s req,
  // external pins
  input wire logic ready_pin,
  output logic bus_reference_clock_out,
  // cycle status
  output rdy_pkg::rdy_bus_s bus_out
);
  import rdy_pkg::*;

  typedef struct packed {
    logic [1:0] ctrl;
    logic [15:0] phase;
    rdy_state_e state;
    logic [4:0] cnt;
    logic is_write;
    logic [15:0] waits;
    logic [15:0] last_waits;
    logic [15:0] cycles;
    logic [15:0] rdata;
    logic [1:0] div;
    logic clk_out;
    rdy_bus_s bus;
  } rdy_ctrl_s;

  rdy_ctrl_s st_r;
  rdy_ctrl_s st_nxt;
  logic ready_async;

  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + `RDY_ONE_16;
  endfunction

  // =====================================================
  // ready input conditioning
  // flip-flop pair
  rdy_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(ready_pin),
    .dout(ready_async)
  );

  logic pol_low;
  logic async_mode;
  logic ready_raw;
  logic ready_act;
  logic [4:0] acc_len;
  logic [4:0] cmd_len;
  assign pol_low = st_r.ctrl[`RDY_CTRL_POL_BIT];
  assign async_mode = st_r.ctrl[`RDY_CTRL_ASYNC_BIT];
  assign acc_len = st_r.phase[`RDY_PH_E_MSB:`RDY_PH_E_LSB];
  assign cmd_len = 5'(st_r.phase[`RDY_PH_C_MSB:`RDY_PH_C_LSB]);
  // synchronised value only in async mode
  assign ready_raw = async_mode ? ready_async : ready_pin;
  assign ready_act = ready_raw ^ pol_low;

  // =====================================================
  // state update
  always_comb begin
    st_nxt = st_r;
    st_nxt.bus.done = 1'b0;
    // reference clock: core clock divided by two
    st_nxt.div = st_r.div + `RDY_CLKDIV_HALF;
    st_nxt.clk_out = st_nxt.div[0];
    case (st_r.state)
      RDY_IDLE: begin
        if (req.start) begin
          st_nxt.is_write = req.is_write;
          st_nxt.waits = '0;
          st_nxt.cnt = cmd_len;
          st_nxt.bus.busy = 1'b1;
          st_nxt.state = (cmd_len == '0) ? RDY_ACC : RDY_CMD;
          if (cmd_len == '0) begin
            // async sample point one clock later for access phase lengths 1 to 30
            st_nxt.cnt = async_mode ? acc_len + `RDY_ASYNC_EXTRA : acc_len;
            st_nxt.bus.cmd_n = 1'b0;
            st_nxt.bus.wr_n = ~req.is_write;
          end
        end
      end
      RDY_CMD: begin
        st_nxt.cnt = st_r.cnt - `RDY_ONE_5;
        if (st_r.cnt == `RDY_ONE_5) begin
          st_nxt.state = RDY_ACC;
          st_nxt.cnt = async_mode ? acc_len + `RDY_ASYNC_EXTRA : acc_len;
          st_nxt.bus.cmd_n = 1'b0;
          st_nxt.bus.wr_n = ~st_r.is_write;
        end
      end
      RDY_ACC: begin
        if (st_r.cnt > `RDY_ONE_5) begin
          st_nxt.cnt = st_r.cnt - `RDY_ONE_5;
        end else begin
          st_nxt.state = RDY_WAIT;
        end
      end
      RDY_WAIT: begin
        if (ready_act) begin
          st_nxt.state = RDY_IDLE;
          st_nxt.bus.cmd_n = 1'b1;
          st_nxt.bus.wr_n = 1'b1;
          st_nxt.bus.busy = 1'b0;
          st_nxt.bus.done = 1'b1;
          st_nxt.last_waits = st_r.waits;
          st_nxt.cycles = inc16(st_r.cycles);
        end else begin
          // one ready wait state, sample again
          st_nxt.waits = inc16(st_r.waits);
        end
      end
      default: begin
        st_nxt.state = RDY_IDLE;
      end
    endcase
    // register port; config writes take effect on the next clock, also inside a running cycle
    if (reg_in.wr) begin
      case (reg_in.addr)
        `RDY_REG_CTRL: st_nxt.ctrl = reg_in.wdata[1:0];
        `RDY_REG_PHASE: st_nxt.phase = reg_in.wdata;
        default: ;
      endcase
    end
    st_nxt.rdata = '0;
    if (reg_in.rd) begin
      case (reg_in.addr)
        `RDY_REG_CTRL: st_nxt.rdata = {14'h0000, st_r.ctrl};
        `RDY_REG_PHASE: st_nxt.rdata = st_r.phase;
        `RDY_REG_STAT: st_nxt.rdata = {11'h000, st_r.state, st_r.bus.busy};
        `RDY_REG_COUNT: st_nxt.rdata = st_r.last_waits;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= `RDY_CTRL_RST;
      st_r.phase <= `RDY_PH_RST;
      st_r.state <= RDY_IDLE;
      st_r.bus.cmd_n <= 1'b1;
      st_r.bus.wr_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign bus_reference_clock_out = st_r.clk_out;
  assign bus_out = st_r.bus;
endmodule
`default_nettype wire

// file: tb/rdy_far.sv
// far-side device answering each cycle on the ready pin
// assumes strobe comes from the controller and core_clk from the bench
`timescale 1ns/1ns
`default_nettype none
module rdy_far (
  // clock
  input wire logic core_clk,
  // strobe in, answer out
  input wire logic cmd_n,
  input wire logic pol,
  input wire logic [3:0] dly,
  output logic ready_pin
);
  logic [3:0] cnt_r;
  always_ff @(posedge core_clk) begin
    if (cmd_n)
      cnt_r <= 4'h0;
    else if (cnt_r != dly)
      cnt_r <= cnt_r + 4'h1;
  end
  assign ready_pin = pol ^ (!cmd_n && cnt_r == dly);
endmodule
`default_nettype wire

// file: tb/rdy_ctrl_asserts.sv
// port checker for the ready controller
// assumes rdy_pkg is compiled first
`timescale 1ns/1ns
`default_nettype none
module rdy_ctrl_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire rdy_pkg::rdy_reg_s reg_in,
  input wire rdy_pkg::rdy_req_s req,
  input wire logic ready_pin,
  input wire rdy_pkg::rdy_bus_s bus_out
);
  logic [1:0] ctl_r, cyc_r;
  logic go, act;
  assign go = req.start && !bus_out.busy;
  assign act = ready_pin ^ cyc_r[0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ====================
  // config seen by the running cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_r <= 2'h0;
      cyc_r <= 2'h0;
    end else begin
      if (reg_in.wr && reg_in.addr == 4'h0)
        ctl_r <= reg_in.wdata[1:0];
      if (go)
        cyc_r <= ctl_r;
    end
  end
  property p_sync; bus_out.done && !cyc_r[1] |-> $past(act); endproperty
  a_sync: assert property (p_sync) else $error("sync end");
  property p_async; bus_out.done && cyc_r[1] |-> $past(act, 3); endproperty
  a_async: assert property (p_async) else $error("async end");
  property p_wait; bus_out.busy && !cyc_r[1] && !act |=> !bus_out.done; endproperty
  a_wait: assert property (p_wait) else $error("no wait");
  property p_ign; go |=> !bus_out.done [*2]; endproperty
  a_ign: assert property (p_ign) else $error("early end");
  property p_amin; go && ctl_r[1] |=> !bus_out.done [*3]; endproperty
  a_amin: assert property (p_amin) else $error("async early");
  property p_go; go |=> bus_out.busy; endproperty
  a_go: assert property (p_go) else $error("no busy");
  property p_end; bus_out.done |-> !bus_out.busy && bus_out.cmd_n; endproperty
  a_end: assert property (p_end) else $error("bad end");
  property p_once; bus_out.done |=> !bus_out.done; endproperty
  a_once: assert property (p_once) else $error("long done");
endmodule
bind rdy_ctrl rdy_ctrl_chk i_chk (.core_clk(core_clk), .rst(rst), .reg_in(reg_in),
  .req(req), .ready_pin(ready_pin), .bus_out(bus_out));
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the ready controller
// assumes design, checker and far model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rdy_pkg::*;
  typedef struct packed {
    logic [1:0] ctl;
    logic [15:0] ph;
    logic [3:0] dly;
    logic [7:0] len;
    logic [3:0] wt;
  } rdy_row_s;
  logic ref_clk, rc0, wrn_seen;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  rdy_reg_s reg_in = '0;
  rdy_req_s req = '0;
  logic [15:0] reg_rdata, rv;
  logic ready_pin;
  logic m_pol = 1'b0;
  logic [3:0] m_dly = 4'h0;
  rdy_bus_s bus_out;
  int fails = 0;
  int cmp_count = 0;
  int n;
  // async rows: len is the sync length they must exceed
  // wt: ready waits expected after the first sample point
  rdy_row_s rows [6] = '{'{2'h0, 16'h0000, 4'h0, 8'h02, 4'h0},
    '{2'h0, 16'h0000, 4'h2, 8'h03, 4'h1}, '{2'h1, 16'h0000, 4'h1, 8'h02, 4'h0},
    '{2'h0, 16'h0303, 4'h0, 8'h07, 4'h0}, '{2'h2, 16'h0000, 4'h0, 8'h02, 4'h1},
    '{2'h3, 16'h0001, 4'h2, 8'h03, 4'h2}};
  always #5 core_clk = ~core_clk;
  rdy_ctrl i_dut (.core_clk(core_clk), .rst(rst), .reg_in(reg_in), .reg_rdata(reg_rdata),
    .req(req), .ready_pin(ready_pin), .bus_reference_clock_out(ref_clk), .bus_out(bus_out));
  rdy_far i_far (.core_clk(core_clk), .cmd_n(bus_out.cmd_n), .pol(m_pol), .dly(m_dly),
    .ready_pin(ready_pin));
  // ====================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_in <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_in <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_in <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_in <= '0;
    #1 d = reg_rdata;
  endtask
  task automatic run(input rdy_row_s r);
    wr(4'h0, {14'h0, r.ctl});
    wr(4'h1, r.ph);
    m_dly <= r.dly;
    m_pol <= r.ctl[0];
    @(posedge core_clk);
    req <= '{1'b1, r.ctl[0]};
    @(posedge core_clk);
    req <= '0;
    n = 0;
    wrn_seen = 1'bx;
    do begin
      @(posedge core_clk);
      #1 n++;
      if (bus_out.cmd_n === 1'b0)
        wrn_seen = bus_out.wr_n;
    end while (bus_out.done !== 1'b1 && n < 40);
    chk({15'h0, wrn_seen}, {15'h0, ~r.ctl[0]});
    rd(4'h3, rv);
    if (r.ctl[1])
      chk({15'h0, n > r.len}, 16'h0001);
    else
      chk(n[15:0], {8'h0, r.len});
    chk(rv, {12'h0, r.wt});
  endtask
  task automatic close_out;
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, rv);
    chk(rv, 16'h0000);
    rd(4'hF, rv);
    chk(rv, 16'h0000);
    @(posedge core_clk);
    #1 rc0 = ref_clk;
    @(posedge core_clk);
    #1 chk({15'h0, rc0 ^ ref_clk}, 16'h0001);
    foreach (rows[i]) run(rows[i]);
    // reset in mid-cycle, then a clean cycle
    m_dly <= 4'hF;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0};
    @(posedge core_clk);
    req <= '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    #1 chk({14'h0, bus_out.busy, bus_out.cmd_n}, 16'h0001);
    @(posedge core_clk);
    rst <= 1'b0;
    run(rows[0]);
    close_out;
  end
endmodule
`default_nettype wire
